/* rtl/icsd_core.sv */
// Purpose: decode fetched words and time each instruction cycle, with skips
// Assumes: i_word holds the prefetched word for the cycle that starts at Q1
// Notes: data for the file register comes in at Q2 on i_rd_data
`timescale 1ns/1ps
`default_nettype none
// Function
// - Every instruction is one 16-bit word except four that take two consecutive words.
// - Decrement-skip operations write the accumulator when the destination bit is clear and the file register when set.
// - A word with ones in its top four bits executed alone acts as a no-operation.
// - A single-word instruction takes one cycle, or two when its skip test is true.
// - A double-word instruction always takes two instruction cycles.
// - Each instruction cycle is four oscillator periods in four sequential phases.
// - In bit operations the bit field picks the bit within the addressed register.
// - The file operand is an eight-bit address from 0 to 255 within the selected bank.
// - Control operands give a program address, a call and return mode bit, or a table mode field.
// - Decrement-skip-when-zero subtracts one, writes the destination, and skips on a zero result.
// - Decrement-skip-when-nonzero subtracts one, writes the destination, and skips on a nonzero result.
// - A taken skip discards the prefetched word and runs a no-operation cycle instead.
// - A taken skip over a double-word instruction costs three cycles with two no-operation cycles.
module icsd_core #(
  parameter int unsigned WORD_W = icsd_pkg::WORD_W,
  parameter int unsigned DATA_W = icsd_pkg::DATA_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WORD_W-1:0] i_word,
  input wire logic [DATA_W-1:0] i_rd_data,
  input wire logic [icsd_pkg::BANK_W-1:0] i_bank_select_pointer,
  input wire logic [DATA_W-1:0] i_working_accumulator,
  output logic o_rd_en,
  output logic [icsd_pkg::BANK_W-1:0] o_bank,
  output logic [icsd_pkg::ADDR_W-1:0] o_addr,
  output logic o_wr_file,
  output logic o_wr_acc,
  output logic [DATA_W-1:0] o_wr_data,
  output logic [2:0] o_bit_sel,
  output logic [icsd_pkg::N_W-1:0] o_prog_addr,
  output logic o_call_mode,
  output logic [1:0] o_table_mode,
  output logic o_nop_cycle,
  output logic o_cycle_done,
  output logic [1:0] o_phase
);
  icsd_pkg::icsd_phase_t phase;
  logic cycle_end;

  icsd_phase_gen u_phase (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .o_phase(phase),
    .o_cycle_end(cycle_end)
  );

  typedef struct packed {
    logic [WORD_W-1:0] ir;
    logic [1:0] flush;    // no-operation cycles still owed
    logic dw_pend;        // next cycle is the second word of a double-word
    logic is_dec;
    logic skip_nz;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] res;
    logic rd_en;
    logic [icsd_pkg::BANK_W-1:0] bank;
    logic [icsd_pkg::ADDR_W-1:0] addr;
    logic wr_file;
    logic wr_acc;
    logic [DATA_W-1:0] wr_data;
    logic [2:0] bit_sel;
    logic [icsd_pkg::N_W-1:0] prog_addr;
    logic call_mode;
    logic [1:0] table_mode;
    logic nop;
    logic done;
    logic [1:0] ph;
  } icsd_state_t;
  icsd_state_t st_q, st_d;

  // recognise the first word of a double-word instruction
  function automatic logic is_double(input logic [WORD_W-1:0] w);
    logic [7:0] t;
    t = w[WORD_W-1 -: 8];
    is_double = (t[7:4] == icsd_pkg::DW_MOVFF_TOP4[7:4])
             || (t[7:1] == icsd_pkg::DW_CALL_TOP7[7:1])
             || (t == icsd_pkg::DW_GOTO_TOP8)
             || (t == icsd_pkg::DW_LFSR_TOP8);
  endfunction

  // phase-ordered decode, read, process and write with skip flushing
  always_comb begin
    logic cur_nop;
    logic zero;
    cur_nop = (st_q.flush != 2'h0) || st_q.dw_pend;
    zero = (st_q.res == '0);
    st_d = st_q;
    st_d.wr_file = 1'b0;
    st_d.wr_acc = 1'b0;
    st_d.rd_en = 1'b0;
    st_d.done = cycle_end; // pulse after every fourth phase
    st_d.ph = phase;
    case (phase)
      icsd_pkg::ICSD_Q1: begin
        st_d.ir = i_word;
        st_d.nop = cur_nop;
        st_d.is_dec = 1'b0;
        if (!cur_nop) begin
          // lone second word has top nibble of ones: decodes to nothing
          if (i_word[WORD_W-1 -: 4] != icsd_pkg::SECOND_NIBBLE) begin
            st_d.is_dec = (i_word[icsd_pkg::OP_LSB +: icsd_pkg::OP_W] == icsd_pkg::OP_DEC_SKIP_ZERO)
                       || (i_word[icsd_pkg::OP_LSB +: icsd_pkg::OP_W] == icsd_pkg::OP_DEC_SKIP_NONZERO);
          end
          st_d.skip_nz = (i_word[icsd_pkg::OP_LSB +: icsd_pkg::OP_W] == icsd_pkg::OP_DEC_SKIP_NONZERO);
          st_d.addr = i_word[icsd_pkg::F_LSB +: icsd_pkg::ADDR_W];
          st_d.bank = i_word[icsd_pkg::A_POS] ? i_bank_select_pointer : icsd_pkg::ACCESS_BANK;
          st_d.bit_sel = i_word[icsd_pkg::B_LSB +: 3];
          st_d.prog_addr = i_word[icsd_pkg::N_W-1:0];
          st_d.call_mode = i_word[icsd_pkg::S_POS];
          st_d.table_mode = i_word[icsd_pkg::M_LSB +: 2];
        end
      end
      icsd_pkg::ICSD_Q2: begin
        st_d.rd_en = st_q.is_dec && !st_q.nop;
        st_d.opnd = i_rd_data;
      end
      icsd_pkg::ICSD_Q3: begin
        st_d.res = st_q.opnd - DATA_W'(1);
      end
      default: begin
        if (st_q.nop) begin
          // owed no-operation cycle: nothing written
          if (st_q.dw_pend) begin
            st_d.dw_pend = 1'b0;
          end else if (st_q.flush != 2'h0) begin
            st_d.flush = st_q.flush - 2'h1;
            // the discarded word opened a double-word: its second word is owed as well
            if (st_q.flush == 2'h1 && is_double(st_q.ir)) begin
              st_d.flush = 2'h1;
            end
          end
        end else begin
          st_d.dw_pend = is_double(st_q.ir);
          if (st_q.is_dec) begin
            st_d.wr_data = st_q.res;
            st_d.wr_file = st_q.ir[icsd_pkg::D_POS];
            st_d.wr_acc = !st_q.ir[icsd_pkg::D_POS];
            if (st_q.skip_nz ? !zero : zero) begin
              st_d.flush = 2'h1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rd_en = st_q.rd_en;
  assign o_bank = st_q.bank;
  assign o_addr = st_q.addr;
  assign o_wr_file = st_q.wr_file;
  assign o_wr_acc = st_q.wr_acc;
  assign o_wr_data = st_q.wr_data;
  assign o_bit_sel = st_q.bit_sel;
  assign o_prog_addr = st_q.prog_addr;
  assign o_call_mode = st_q.call_mode;
  assign o_table_mode = st_q.table_mode;
  assign o_nop_cycle = st_q.nop;
  assign o_cycle_done = st_q.done;
  assign o_phase = st_q.ph;

  // phase sequence and write timing
  phase_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (phase == icsd_pkg::ICSD_Q4) |=> (phase == icsd_pkg::ICSD_Q1) ##3 (phase == icsd_pkg::ICSD_Q4))
    else $error("phase order broken");
  write_after_q4_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) |-> $past(phase) == icsd_pkg::ICSD_Q4)
    else $error("write outside q4");
  dest_exclusive_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(o_wr_file && o_wr_acc))
    else $error("two destinations");
  nop_no_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_cycle_done && o_nop_cycle) |-> !(o_wr_file || o_wr_acc))
    else $error("write in nop cycle");
  skip_gives_nop_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) && (st_q.skip_nz ? (o_wr_data != 8'h00) : (o_wr_data == 8'h00))
    |-> ##2 o_nop_cycle)
    else $error("skip without nop cycle");
  dec_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) |-> o_wr_data == DATA_W'($past(st_q.opnd, 2) - 1))
    else $error("decrement wrong");
  dw_second_nop_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (phase == icsd_pkg::ICSD_Q1 && st_q.dw_pend) |=> st_d.nop || st_q.nop)
    else $error("second word executed");
  access_bank_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (phase == icsd_pkg::ICSD_Q1 && !st_q.dw_pend && st_q.flush == 2'h0 && !i_word[icsd_pkg::A_POS])
    |=> o_bank == icsd_pkg::ACCESS_BANK)
    else $error("access bank not chosen");
  read_in_q2_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_rd_en |-> $past(phase) == icsd_pkg::ICSD_Q2)
    else $error("read outside q2");

  // live decode slot: a Q1 edge that is not owed a no-operation
  logic q1_live;
  assign q1_live = (phase == icsd_pkg::ICSD_Q1) && (st_q.flush == 2'h0) && !st_q.dw_pend;

  // cycle framing as seen at the outputs
  cycle_done_q4_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_cycle_done |-> $past(phase) == icsd_pkg::ICSD_Q4)
    else $error("cycle end outside q4");
  done_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_cycle_done |=> !o_cycle_done [*3] ##1 o_cycle_done)
    else $error("cycle length not four");
  phase_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_phase == $past(phase))
    else $error("phase output lag wrong");

  // read and write strobes
  rd_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_rd_en |=> !o_rd_en)
    else $error("read strobe too long");
  wr_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) |=> !(o_wr_file || o_wr_acc))
    else $error("write strobe too long");
  read_in_live_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_rd_en |-> !o_nop_cycle)
    else $error("read in nop cycle");
  read_then_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) |-> $past(o_rd_en, 2))
    else $error("write without read");
  opnd_taken_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (phase == icsd_pkg::ICSD_Q2 && st_q.is_dec && !st_q.nop) |=> st_q.opnd == $past(i_rd_data))
    else $error("operand not taken in q2");

  // destination steering and decoded operations
  file_dest_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_wr_file |-> st_q.ir[icsd_pkg::D_POS])
    else $error("file write with d clear");
  acc_dest_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_wr_acc |-> !st_q.ir[icsd_pkg::D_POS])
    else $error("accumulator write with d set");
  dec_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) |-> (st_q.ir[icsd_pkg::OP_LSB +: icsd_pkg::OP_W] == icsd_pkg::OP_DEC_SKIP_ZERO)
      || (st_q.ir[icsd_pkg::OP_LSB +: icsd_pkg::OP_W] == icsd_pkg::OP_DEC_SKIP_NONZERO))
    else $error("write from other opcode");

  // skip decisions and cycle counts
  zero_no_skip_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) && (o_wr_data != 8'h00)
      && (st_q.ir[icsd_pkg::OP_LSB +: icsd_pkg::OP_W] == icsd_pkg::OP_DEC_SKIP_ZERO) |-> ##2 !o_nop_cycle)
    else $error("skip on nonzero result");
  nz_no_skip_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_wr_file || o_wr_acc) && (o_wr_data == 8'h00)
      && (st_q.ir[icsd_pkg::OP_LSB +: icsd_pkg::OP_W] == icsd_pkg::OP_DEC_SKIP_NONZERO) |-> ##2 !o_nop_cycle)
    else $error("skip on zero result");
  plain_one_cycle_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_cycle_done && !o_nop_cycle && !is_double(st_q.ir) && !(o_wr_file || o_wr_acc)) |-> ##2 !o_nop_cycle)
    else $error("single word took two cycles");
  dw_then_nop_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_cycle_done && !o_nop_cycle && is_double(st_q.ir)) |-> ##2 o_nop_cycle)
    else $error("double word not two cycles");
  dw_skip_extra_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_cycle_done && o_nop_cycle && st_q.flush == 2'h1 && is_double(st_q.ir)) |-> ##2 o_nop_cycle)
    else $error("skip over double word too short");
  second_inert_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (q1_live && i_word[WORD_W-1 -: 4] == icsd_pkg::SECOND_NIBBLE) |=> !st_q.is_dec)
    else $error("lone second word decoded");

  // operand fields taken at a live decode and held through owed cycles
  addr_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    q1_live |=> o_addr == $past(i_word[icsd_pkg::F_LSB +: icsd_pkg::ADDR_W]))
    else $error("file address field wrong");
  bit_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    q1_live |=> o_bit_sel == $past(i_word[icsd_pkg::B_LSB +: 3]))
    else $error("bit field wrong");
  prog_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    q1_live |=> o_prog_addr == $past(i_word[icsd_pkg::N_W-1:0]))
    else $error("program address field wrong");
  mode_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    q1_live |=> (o_call_mode == $past(i_word[icsd_pkg::S_POS]))
      && (o_table_mode == $past(i_word[icsd_pkg::M_LSB +: 2])))
    else $error("mode field wrong");
  bank_ptr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (q1_live && i_word[icsd_pkg::A_POS]) |=> o_bank == $past(i_bank_select_pointer))
    else $error("pointer bank not chosen");
  nop_fields_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (phase == icsd_pkg::ICSD_Q1 && !q1_live) |=> $stable(o_addr) && $stable(o_bank) && $stable(o_prog_addr))
    else $error("fields changed in nop cycle");

  skip_taken_c: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_cycle_done && o_nop_cycle);
  write_file_c: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_wr_file);
  write_acc_c: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_wr_acc);
  double_word_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    st_q.nop && st_q.flush == 2'h1 && is_double(st_q.ir));
endmodule
`default_nettype wire

/* rtl/icsd_pkg.sv */
// Purpose: shared constants for the instruction cycle and skip decoder
// Assumes: 16-bit program words, 8-bit data, four phases per instruction cycle
// Notes: opcodes are matched on the top byte with the low two bits masked off
package icsd_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned PHASES = 4;
  // byte-operation operand fields
  localparam int unsigned F_LSB = 0;
  localparam int unsigned A_POS = 8;
  localparam int unsigned D_POS = 9;
  localparam int unsigned B_LSB = 9;
  localparam int unsigned OP_LSB = 10;
  localparam int unsigned OP_W = 6;
  // control-operation operand fields
  localparam int unsigned S_POS = 0;
  localparam int unsigned M_LSB = 0;
  localparam int unsigned N_W = 11;
  // opcode patterns (top six bits)
  localparam logic [5:0] OP_DEC_SKIP_ZERO = 6'h0b;    // 0010 11
  localparam logic [5:0] OP_DEC_SKIP_NONZERO = 6'h13; // 0100 11
  // top nibble of a double-word second word; none of the first words below has it
  localparam logic [3:0] SECOND_NIBBLE = 4'hf;
  localparam logic [7:0] DW_MOVFF_TOP4 = 8'hc0;       // top nibble 1100
  localparam logic [7:0] DW_CALL_TOP7 = 8'hec;        // 1110 110s
  localparam logic [7:0] DW_GOTO_TOP8 = 8'hef;
  localparam logic [7:0] DW_LFSR_TOP8 = 8'hee;
  localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
  typedef enum logic [1:0] {ICSD_Q1, ICSD_Q2, ICSD_Q3, ICSD_Q4} icsd_phase_t;
endpackage

/* rtl/icsd_phase_gen.sv */
// Purpose: four-phase sequencer for the instruction cycle
// Assumes: one oscillator period per clock
// Notes: o_cycle_end pulses in the fourth phase
`timescale 1ns/1ps
`default_nettype none
module icsd_phase_gen (
  input wire logic i_clk,
  input wire logic i_rst_b,
  output icsd_pkg::icsd_phase_t o_phase,
  output logic o_cycle_end
);
  typedef struct packed {
    icsd_pkg::icsd_phase_t phase;
  } icsd_pg_state_t;
  icsd_pg_state_t st_q, st_d;

  // advance one phase per oscillator period
  always_comb begin
    st_d = st_q;
    case (st_q.phase)
      icsd_pkg::ICSD_Q1: st_d.phase = icsd_pkg::ICSD_Q2;
      icsd_pkg::ICSD_Q2: st_d.phase = icsd_pkg::ICSD_Q3;
      icsd_pkg::ICSD_Q3: st_d.phase = icsd_pkg::ICSD_Q4;
      default: st_d.phase = icsd_pkg::ICSD_Q1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{phase: icsd_pkg::ICSD_Q1};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_phase = st_q.phase;
  assign o_cycle_end = (st_q.phase == icsd_pkg::ICSD_Q4);
endmodule
`default_nettype wire

/* tb/icsd_mem_model.sv */
// Purpose: program word source and data register file facing the core
// Assumes: a new word is due at every fourth clock edge after reset release
// Notes: the bench loads prog and file directly before each run
`timescale 1ns/1ps
`default_nettype none
module icsd_mem_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_bank,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_file,
  input wire logic i_wr_acc,
  input wire logic [7:0] i_wr_data,
  output logic [15:0] o_word,
  output logic [7:0] o_rd_data
);
  logic [15:0] prog [0:15];
  logic [7:0] file [0:4095];
  logic [7:0] acc_q;
  logic [31:0] cnt;
  // period counter and destination writes
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
      if (i_wr_file) file[{i_bank, i_addr}] <= i_wr_data;
      if (i_wr_acc) acc_q <= i_wr_data;
    end
  end
  // words and file data change only off the sampling edge
  initial begin
    o_word = 16'h0000;
    o_rd_data = 8'h00;
  end
  always @(negedge i_clk) begin
    o_word <= prog[cnt[5:2]];
    o_rd_data <= file[{i_bank, i_addr}];
  end
endmodule
`default_nettype wire

/* tb/tb_instruction_cycle_skip_decoder.sv */
// Purpose: self-checking bench for the decode and skip timing core
// Assumes: the memory model supplies words and file data
// Notes: each scenario resets the core and runs a short program
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end
module tb_instruction_cycle_skip_decoder;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] bsp = 4'h0;
  logic [15:0] word;
  logic [7:0] rd_data, addr, wr_data;
  logic rd_en, wr_file, wr_acc, call_mode, nop_cycle, cycle_done;
  logic [3:0] bank;
  logic [2:0] bit_sel;
  logic [10:0] prog_addr;
  logic [1:0] table_mode, phase;
  int err_total = 0;
  int n_compared = 0;
  int nop_clk, wrf, wra, phase_bad, done_n, rdn;
  logic [15:0] firsts [4] = '{16'hc123, 16'hec01, 16'hee00, 16'hef00};
  // device under test and its far side
  icsd_core i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_word(word), .i_rd_data(rd_data),
    .i_bank_select_pointer(bsp), .i_working_accumulator(8'h5a), .o_rd_en(rd_en), .o_bank(bank),
    .o_addr(addr), .o_wr_file(wr_file), .o_wr_acc(wr_acc), .o_wr_data(wr_data), .o_bit_sel(bit_sel),
    .o_prog_addr(prog_addr), .o_call_mode(call_mode), .o_table_mode(table_mode),
    .o_nop_cycle(nop_cycle), .o_cycle_done(cycle_done), .o_phase(phase));
  icsd_mem_model i_mem (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bank(bank), .i_addr(addr),
    .i_wr_file(wr_file), .i_wr_acc(wr_acc), .i_wr_data(wr_data), .o_word(word), .o_rd_data(rd_data));
  // 40 MHz clock
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // reset, load a program padded with w3, run ten instruction cycles
  task automatic run_prog(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2,
                          input logic [15:0] w3, input logic [3:0] b);
    logic [1:0] prev;
    i_rst_b = 1'b0;
    bsp = b;
    for (int k = 0; k < 16; k++) i_mem.prog[k] = w3;
    i_mem.prog[0] = w0;
    i_mem.prog[1] = w1;
    i_mem.prog[2] = w2;
    repeat (20) @(negedge i_clk);
    i_rst_b = 1'b1;
    nop_clk = 0;
    wrf = 0;
    wra = 0;
    phase_bad = 0;
    done_n = 0;
    rdn = 0;
    prev = 2'h0;
    for (int k = 0; k < 40; k++) begin
      @(negedge i_clk);
      nop_clk += (nop_cycle === 1'b1);
      wrf += (wr_file === 1'b1);
      wra += (wr_acc === 1'b1);
      done_n += (cycle_done === 1'b1);
      rdn += (rd_en === 1'b1);
      if (k > 2 && phase !== prev + 2'h1) phase_bad++;
      prev = phase;
    end
  endtask
  // zero result skips; access bit clear ignores the pointer
  task automatic s_skip_zero();
    i_mem.file[12'h005] = 8'h01;
    i_mem.file[12'h305] = 8'h77;
    run_prog(16'h2e05, 16'h0000, 16'h0000, 16'h0000, 4'h3);
    `CHK(i_mem.file[12'h005], 8'h00)
    `CHK(i_mem.file[12'h305], 8'h77)
    `CHK(wrf, 1)
    `CHK(nop_clk, 4)
    `CHK(phase_bad, 0)
    `CHK(done_n, 10)
    `CHK(rdn, 1)
  endtask
  // nonzero result to the accumulator, no skip
  task automatic s_acc_dest();
    i_mem.file[12'h007] = 8'h03;
    run_prog(16'h2c07, 16'h0000, 16'h0000, 16'h0000, 4'h0);
    `CHK(i_mem.acc_q, 8'h02)
    `CHK(i_mem.file[12'h007], 8'h03)
    `CHK(wra, 1)
    `CHK(nop_clk, 0)
  endtask
  // nonzero variant in a banked register, skip taken
  task automatic s_nz_skip();
    i_mem.file[12'h210] = 8'h05;
    run_prog(16'h4f10, 16'h0000, 16'h0000, 16'h0000, 4'h2);
    `CHK(i_mem.file[12'h210], 8'h04)
    `CHK(nop_clk, 4)
  endtask
  // nonzero variant at the top address, result zero, no skip
  task automatic s_nz_top();
    i_mem.file[12'h0ff] = 8'h01;
    run_prog(16'h4eff, 16'h0000, 16'h0000, 16'h0000, 4'h5);
    `CHK(i_mem.file[12'h0ff], 8'h00)
    `CHK(nop_clk, 0)
  endtask
  // decrement of zero wraps and does not skip
  task automatic s_wrap();
    i_mem.file[12'h000] = 8'h00;
    run_prog(16'h2e00, 16'h0000, 16'h0000, 16'h0000, 4'h0);
    `CHK(i_mem.file[12'h000], 8'hff)
    `CHK(nop_clk, 0)
  endtask
  // taken skip over a double-word instruction
  task automatic s_skip_dw();
    i_mem.file[12'h011] = 8'h01;
    run_prog(16'h2e11, 16'hef00, 16'hf000, 16'h0000, 4'h0);
    `CHK(i_mem.file[12'h011], 8'h00)
    `CHK(nop_clk, 8)
  endtask
  // each double-word first word makes its second word a no-operation
  task automatic s_dw_pairs();
    for (int k = 0; k < 4; k++) begin
      run_prog(firsts[k], 16'hf456, 16'h0000, 16'h0000, 4'h0);
      `CHK(nop_clk, 4)
      `CHK(wrf + wra, 0)
      `CHK(rdn, 0)
    end
  endtask
  // lone second word writes nothing; operand fields
  task automatic s_fields();
    run_prog(16'hf000, 16'h9a55, 16'h9a55, 16'h9a55, 4'h0);
    `CHK(wrf + wra, 0)
    `CHK(bit_sel, 3'h5)
    `CHK(prog_addr, 11'h255)
    `CHK(call_mode, 1'h1)
    `CHK(table_mode, 2'h1)
    `CHK(addr, 8'h55)
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    s_skip_zero();
    s_acc_dest();
    s_nz_skip();
    s_nz_top();
    s_wrap();
    s_skip_dw();
    s_dw_pairs();
    s_fields();
    finish_test();
  end
  // watchdog, well past the roughly 700 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
